// ==== include/usb_fifo_port_defs.svh ====
`ifndef USB_FIFO_PORT_DEFS_SVH
`define USB_FIFO_PORT_DEFS_SVH

// ----------------------------------------------------------------------------
// byte bus layout
// ----------------------------------------------------------------------------
`define FIFO_BUS_BIT_LSB 0
`define FIFO_BUS_BIT_MSB 7

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     20
`define FLAG_HOLD_NS      80
// least time, rounded up to whole cycles, at least one
`define FLAG_HOLD_CYC     (((`FLAG_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                           ((`FLAG_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define FLAG_HOLD_W       3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
// idle levels of {send_now_wake_n, wr, rd_n}
`define STRB_IDLE         3'h5
`define FIFO_DEPTH_DEF    16

`endif

// ==== include/usb_fifo_port_pkg.sv ====
`include "usb_fifo_port_defs.svh"

package usb_fifo_port_pkg;

  // one byte of the fifo bus
  typedef logic [`FIFO_BUS_BIT_MSB:`FIFO_BUS_BIT_LSB] byte_t;

  // phase of a read strobe
  typedef enum logic {
    RD_IDLE,
    RD_DRIVE
  } rd_phase_t;

endpackage

// ==== include/fifo_byte_if.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// push / pop handshake of one byte fifo
// ----------------------------------------------------------------------------
interface fifo_byte_if #(
  parameter int WIDTH = 8
);
  logic             push_valid;  // byte offered
  logic             push_ready;  // room for it
  logic [WIDTH-1:0] push_data;   // offered byte
  logic             pop_valid;   // head byte present
  logic             pop_ready;   // consume head
  logic [WIDTH-1:0] pop_data;    // head byte

  // the storage side
  modport store (
    input  push_valid,
    input  push_data,
    input  pop_ready,
    output push_ready,
    output pop_valid,
    output pop_data
  );

  // the side that fills and drains it
  modport user (
    output push_valid,
    output push_data,
    output pop_ready,
    input  push_ready,
    input  pop_valid,
    input  pop_data
  );
endinterface

// ==== design/byte_fifo.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// byte fifo: push ignored when full, pop ignored when empty
// ----------------------------------------------------------------------------
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic  clock,
  input wire logic  rst_n,
  // handshake
  fifo_byte_if.store port
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr_q;      // next write slot
  logic [AW-1:0]    rd_ptr_q;      // head slot
  logic [AW:0]      count_q;       // bytes held
  logic             push_ok;       // push accepted
  logic             pop_ok;        // pop accepted

  assign port.push_ready = (count_q != (AW+1)'(DEPTH));
  assign port.pop_valid  = (count_q != '0);
  assign port.pop_data   = mem[rd_ptr_q];
  assign push_ok         = port.push_valid & port.push_ready;  // [R19]
  assign pop_ok          = port.pop_ready & port.pop_valid;    // [R19]

  // storage write, no reset needed
  always_ff @(posedge clock) begin
    if (push_ok) begin
      mem[wr_ptr_q] <= port.push_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop_ok) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
      end
      // simultaneous push and pop keep the level
      if (push_ok && !pop_ok) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop_ok && !push_ok) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule

// ==== design/usb_parallel_fifo_port.sv ====
`timescale 1ns/1ps

// Summary of operation
// [R1] eight-line bidirectional byte bus per channel
// [R2] receive flag low while receive byte waits
// [R3] host reads only while receive flag low
// [R4] transmit flag low while transmit has room
// [R5] host writes only while transmit flag low
// [R6] drive receive byte only while read low
// [R7] read rising edge consumes byte, advances
// [R8] write falling edge captures bus byte
// [R9] receive flag high 80 ns after read
// [R10] transmit flag high 80 ns after write
// [R11] host read strobe low at least 50 ns
// [R12] host read high 50 ns plus holdoff
// [R13] host write strobe high at least 50 ns
// [R14] host write low at least 50 ns
// [R15] wake pulse while suspended requests resume; code requests it only with remote_wake_en set
// [R16] wake pulse when active flushes transmit data
// [R17] flags undriven during device reset
// [R18] each channel enabled independently, both together
// [R19] ignore reads when empty, writes when full
module usb_parallel_fifo_port
  import usb_fifo_port_pkg::*;
#(
  parameter int NUM_CH     = 2,
  parameter int RX_DEPTH   = `FIFO_DEPTH_DEF,
  parameter int TX_DEPTH   = `FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  // fifo byte bus pins
  input  wire logic [NUM_CH-1:0][7:0]        bus_in,
  output logic      [NUM_CH-1:0][7:0]        bus_out,
  output logic      [NUM_CH-1:0]             bus_oe,
  // strobe pins
  input  wire logic [NUM_CH-1:0]             rd_n,
  input  wire logic [NUM_CH-1:0]             wr,
  input  wire logic [NUM_CH-1:0]             send_now_wake_n,
  // status flag pins
  output logic      [NUM_CH-1:0]             rx_avail_n,
  output logic      [NUM_CH-1:0]             rx_avail_oe,
  output logic      [NUM_CH-1:0]             tx_space_n,
  output logic      [NUM_CH-1:0]             tx_space_oe,
  // channel configuration and usb state
  input  wire logic [NUM_CH-1:0]             fifo_mode_en,
  input  wire logic [NUM_CH-1:0]             remote_wake_en,
  input  wire logic [NUM_CH-1:0]             suspend_indicator_n,
  // usb side receive stream into the device
  input  wire logic [NUM_CH-1:0]             usb_rx_valid,
  input  wire logic [NUM_CH-1:0][7:0]        usb_rx_data,
  output logic      [NUM_CH-1:0]             usb_rx_ready,
  // usb side transmit stream out of the device
  output logic      [NUM_CH-1:0]             usb_tx_valid,
  output logic      [NUM_CH-1:0][7:0]        usb_tx_data,
  input  wire logic [NUM_CH-1:0]             usb_tx_ready,
  // usb side requests
  output logic      [NUM_CH-1:0]             send_now,
  output logic      [NUM_CH-1:0]             resume_req
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta_q;  // first reset stage
  logic rst_n_q;     // released reset used everywhere

  // assert at once, release after two edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // per channel port
  // --------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch  // [R18]

    // pin synchronisers: {wake, wr, rd}
    logic [2:0]             strb_m_q;      // first stage
    logic [2:0]             strb_s_q;      // second stage
    logic [2:0]             strb_p_q;      // previous synced value
    byte_t                  dat_m_q;       // bus first stage
    byte_t                  dat_s_q;       // bus second stage
    byte_t                  dat_p_q;       // bus one sample earlier

    // edges of the synced strobes
    logic                   rd_fall;       // read strobe starts
    logic                   rd_rise;       // read strobe ends
    logic                   wr_fall;       // write strobe ends
    logic                   wake_fall;     // wake pin strobed low

    // read path state
    rd_phase_t              rd_phase_q;    // idle or driving
    byte_t                  bus_out_q;     // byte on the pins
    logic                   bus_oe_q;      // bus driven
    logic                   rx_pop;        // consume head byte

    // flag state
    logic [`FLAG_HOLD_W-1:0] rx_hold_q;    // receive flag holdoff
    logic [`FLAG_HOLD_W-1:0] tx_hold_q;    // transmit flag holdoff
    logic                   rx_avail_n_q;  // receive flag level
    logic                   tx_space_n_q;  // transmit flag level
    logic                   flag_oe_q;     // flags driven

    // usb side pulses
    logic                   send_now_q;    // flush request
    logic                   resume_q;      // resume request

    // fifos between usb and pins
    fifo_byte_if #(.WIDTH(8)) rx_if ();
    fifo_byte_if #(.WIDTH(8)) tx_if ();

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // strobes pass two flops before any edge detection
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        strb_m_q <= `STRB_IDLE;
        strb_s_q <= `STRB_IDLE;
        strb_p_q <= `STRB_IDLE;
      end else begin
        strb_m_q <= {send_now_wake_n[c], wr[c], rd_n[c]};
        strb_s_q <= strb_m_q;
        strb_p_q <= strb_s_q;
      end
    end

    // bus byte aligned one sample before the strobe edge
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        dat_m_q <= 8'h00;
        dat_s_q <= 8'h00;
        dat_p_q <= 8'h00;
      end else begin
        dat_m_q <= bus_in[c];
        dat_s_q <= dat_m_q;
        dat_p_q <= dat_s_q;
      end
    end

    assign rd_fall   =  strb_p_q[0] & ~strb_s_q[0];
    assign rd_rise   = ~strb_p_q[0] &  strb_s_q[0];
    assign wr_fall   =  strb_p_q[1] & ~strb_s_q[1];
    assign wake_fall =  strb_p_q[2] & ~strb_s_q[2];

    // ------------------------------------------------------------------------
    // fifos
    // ------------------------------------------------------------------------
    byte_fifo #(
      .WIDTH (8),
      .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
      .clock (clock),
      .rst_n (rst_n_q),
      .port  (rx_if.store)
    );

    byte_fifo #(
      .WIDTH (8),
      .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
      .clock (clock),
      .rst_n (rst_n_q),
      .port  (tx_if.store)
    );

    // usb fills the receive fifo
    assign rx_if.push_valid = usb_rx_valid[c];
    assign rx_if.push_data  = usb_rx_data[c];
    assign usb_rx_ready[c]  = rx_if.push_ready;

    // usb drains the transmit fifo
    assign usb_tx_valid[c]  = tx_if.pop_valid;
    assign usb_tx_data[c]   = tx_if.pop_data;
    assign tx_if.pop_ready  = usb_tx_ready[c];

    // ------------------------------------------------------------------------
    // read strobe
    // ------------------------------------------------------------------------
    // pop only at the end of a strobe, empty fifo ignores it
    assign rx_pop          = rd_rise & (rd_phase_q == RD_DRIVE) & fifo_mode_en[c];  // [R7] [R19]
    assign rx_if.pop_ready = rx_pop;

    // drive head byte while the strobe is low
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        rd_phase_q <= RD_IDLE;
        bus_out_q  <= 8'h00;
        bus_oe_q   <= 1'b0;
      end else if (!fifo_mode_en[c]) begin
        // channel not in this mode: bus released
        rd_phase_q <= RD_IDLE;
        bus_oe_q   <= 1'b0;
      end else begin
        unique case (rd_phase_q)
          RD_IDLE: begin
            if (rd_fall) begin
              rd_phase_q <= RD_DRIVE;
              bus_out_q  <= rx_if.pop_data;  // [R1]
              bus_oe_q   <= 1'b1;            // [R6]
            end
          end
          RD_DRIVE: begin
            if (rd_rise) begin
              rd_phase_q <= RD_IDLE;
              bus_oe_q   <= 1'b0;            // [R6]
            end
          end
        endcase
      end
    end

    // ------------------------------------------------------------------------
    // write strobe
    // ------------------------------------------------------------------------
    // capture at falling edge, full fifo drops the byte
    assign tx_if.push_valid = wr_fall & fifo_mode_en[c];  // [R8] [R19]
    assign tx_if.push_data  = dat_p_q;                    // [R1]

    // ------------------------------------------------------------------------
    // flag holdoff counters
    // ------------------------------------------------------------------------
    // receive flag held inactive after each read
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        rx_hold_q <= '0;
      end else if (rx_pop) begin
        rx_hold_q <= `FLAG_HOLD_W'(`FLAG_HOLD_CYC);  // [R9]
      end else if (rx_hold_q != '0) begin
        rx_hold_q <= rx_hold_q - `FLAG_HOLD_W'(1);
      end
    end

    // transmit flag held inactive after each write
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        tx_hold_q <= '0;
      end else if (tx_if.push_valid) begin
        tx_hold_q <= `FLAG_HOLD_W'(`FLAG_HOLD_CYC);  // [R10]
      end else if (tx_hold_q != '0) begin
        tx_hold_q <= tx_hold_q - `FLAG_HOLD_W'(1);
      end
    end

    // ------------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------------
    // low only with data waiting (receive) or room free (transmit), no holdoff running and mode on
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        rx_avail_n_q <= 1'b1;
        tx_space_n_q <= 1'b1;
      end else begin
        rx_avail_n_q <= ~rx_if.pop_valid | rx_pop | (rx_hold_q != '0)
                        | ~fifo_mode_en[c];                          // [R2] [R9]
        tx_space_n_q <= ~tx_if.push_ready | tx_if.push_valid | (tx_hold_q != '0)
                        | ~fifo_mode_en[c];                          // [R4] [R10]
      end
    end

    // flags released while reset or mode off
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        flag_oe_q <= 1'b0;  // [R17]
      end else begin
        flag_oe_q <= fifo_mode_en[c];
      end
    end

    // ------------------------------------------------------------------------
    // send now and wakeup
    // ------------------------------------------------------------------------
    // suspended: resume if enabled; active: flush transmit data
    always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
        send_now_q <= 1'b0;
        resume_q   <= 1'b0;
      end else begin
        send_now_q <= wake_fall & fifo_mode_en[c] & ~suspend_indicator_n[c];  // [R16]
        resume_q   <= wake_fall & fifo_mode_en[c] & suspend_indicator_n[c]
                      & remote_wake_en[c];                                   // [R15]
      end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign bus_out[c]     = bus_out_q;
    assign bus_oe[c]      = bus_oe_q;
    assign rx_avail_n[c]  = rx_avail_n_q;
    assign rx_avail_oe[c] = flag_oe_q;
    assign tx_space_n[c]  = tx_space_n_q;
    assign tx_space_oe[c] = flag_oe_q;
    assign send_now[c]    = send_now_q;
    assign resume_req[c]  = resume_q;
  end

endmodule

// ==== verification/usb_fifo_port_props.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// port checker, channel 0
// ----------------------------------------------------------------------------
module usb_fifo_port_props #(
  parameter int NUM_CH = 2
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              arst_n,
  // strobes and usb state
  input wire logic [NUM_CH-1:0] rd_n,
  input wire logic [NUM_CH-1:0] wr,
  input wire logic [NUM_CH-1:0] send_now_wake_n,
  input wire logic [NUM_CH-1:0] remote_wake_en,
  input wire logic [NUM_CH-1:0] suspend_indicator_n,
  // bus enable and flags
  input wire logic [NUM_CH-1:0] bus_oe,
  input wire logic [NUM_CH-1:0] rx_avail_n,
  input wire logic [NUM_CH-1:0] rx_avail_oe,
  input wire logic [NUM_CH-1:0] tx_space_n,
  input wire logic [NUM_CH-1:0] tx_space_oe,
  // usb side requests
  input wire logic [NUM_CH-1:0] send_now,
  input wire logic [NUM_CH-1:0] resume_req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // wake strobe falling at the pin
  sequence s_wake_fall;
    $fell(send_now_wake_n[0]);
  endsequence

  a_bus_on_read: assert property ($rose(bus_oe[0]) |-> !$past(rd_n[0]) && !$past(rd_n[0], 2))
    else $error("bus driven without read strobe");
  a_bus_hold: assert property (!rd_n[0] && bus_oe[0] |=> bus_oe[0])
    else $error("bus released during read strobe");
  a_rd_flag_up: assert property ($rose(rd_n[0]) && bus_oe[0] |-> ##[1:6] rx_avail_n[0])
    else $error("receive flag not raised after read");
  a_rx_holdoff: assert property ($rose(rx_avail_n[0]) |-> rx_avail_n[0] [*4])
    else $error("receive flag low too soon");
  a_wr_flag_up: assert property ($fell(wr[0]) && !tx_space_n[0] |-> ##[1:6] tx_space_n[0])
    else $error("transmit flag not raised after write");
  a_tx_holdoff: assert property ($rose(tx_space_n[0]) |-> tx_space_n[0] [*4])
    else $error("transmit flag low too soon");
  a_flags_float: assert property (disable iff (1'b0) !arst_n |-> !rx_avail_oe[0] && !tx_space_oe[0])
    else $error("flag driven during reset");
  a_wake_flush: assert property (s_wake_fall ##0 !suspend_indicator_n[0] |-> ##[2:6] send_now[0])
    else $error("no flush after wake strobe");
  a_wake_resume: assert property (s_wake_fall ##0 (suspend_indicator_n[0] && remote_wake_en[0])
    |-> ##[2:6] resume_req[0])
    else $error("no resume after wake strobe");
  a_no_resume: assert property (s_wake_fall ##0 !remote_wake_en[0] |=> !resume_req[0] [*7])
    else $error("resume without remote wake");
endmodule

bind usb_parallel_fifo_port usb_fifo_port_props #(.NUM_CH(NUM_CH)) u_props (
  .clock(clock), .arst_n(arst_n), .rd_n(rd_n), .wr(wr), .send_now_wake_n(send_now_wake_n),
  .remote_wake_en(remote_wake_en), .suspend_indicator_n(suspend_indicator_n), .bus_oe(bus_oe),
  .rx_avail_n(rx_avail_n), .rx_avail_oe(rx_avail_oe), .tx_space_n(tx_space_n),
  .tx_space_oe(tx_space_oe), .send_now(send_now), .resume_req(resume_req));

// ==== verification/usb_fifo_mcu_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// external controller on one channel
// ----------------------------------------------------------------------------
module usb_fifo_mcu_model
  import usb_fifo_port_pkg::*;
(
  // clock and pin levels
  input  wire logic  clock,
  input  wire logic  rx_avail_n,
  input  wire logic  tx_space_n,
  input  wire byte_t bus,
  // strobes and bus drive
  output logic       rd_n,
  output logic       wr,
  output logic       wake_n,
  output byte_t      drv_data,
  output logic       drv_oe
);
  // idle strobes, bus released
  initial begin
    rd_n = 1'b1;
    wr = 1'b0;
    wake_n = 1'b1;
    drv_data = 8'h00;
    drv_oe = 1'b0;
  end

  // poll a flag for low, bounded
  task automatic wait_low(input bit use_tx, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(negedge clock);
      ok = use_tx ? !tx_space_n : !rx_avail_n;
    end
  endtask

  // one read cycle; blind skips the flag
  task automatic read_byte(input bit blind, output byte_t b, output bit ok);
    ok = 1'b1;
    if (!blind) wait_low(1'b0, ok);
    else @(negedge clock);
    rd_n = 1'b0;
    repeat (5) @(negedge clock);
    b = bus;
    rd_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask

  // one write cycle; blind skips the flag
  task automatic write_byte(input bit blind, input byte_t b, output bit ok);
    ok = 1'b1;
    if (!blind) wait_low(1'b1, ok);
    else @(negedge clock);
    drv_data = b;
    drv_oe = 1'b1;
    repeat (2) @(negedge clock);
    wr = 1'b1;
    repeat (4) @(negedge clock);
    wr = 1'b0;
    repeat (3) @(negedge clock);
    drv_oe = 1'b0;
    drv_data = ~b;
  endtask

  // low pulse on the wake pin
  task automatic wake_pulse();
    @(negedge clock);
    wake_n = 1'b0;
    repeat (3) @(negedge clock);
    wake_n = 1'b1;
  endtask
endmodule

// ==== verification/usb_parallel_fifo_port_bench.sv ====
`timescale 1ns/1ps

module usb_parallel_fifo_port_bench;
  import usb_fifo_port_pkg::*;

  // ----------------------------------------------------------------------------
  // pins and bookkeeping
  // ----------------------------------------------------------------------------
  logic            clock;
  logic            arst_n;
  wire  [1:0][7:0] bus_in;
  logic [1:0][7:0] bus_out, rxd, txd;
  wire  [1:0][7:0] m_dat;
  wire  [1:0]      rd_n, wr, wake_n, m_oe;
  logic [1:0]      bus_oe, rx_n, rx_oe, tx_n, tx_oe, snow, resm, rxr, txv;
  logic [1:0]      mode, rwe, susp, rxv, txr;
  int              mismatches, checks, cyc;

  always #10 clock = ~clock;

  // two channels, each with its controller; bus and flags pulled up
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign bus_in[c] = bus_oe[c] ? bus_out[c] : (m_oe[c] ? m_dat[c] : 8'hFF);
    usb_fifo_mcu_model u_mcu (.clock(clock), .rx_avail_n(rx_oe[c] ? rx_n[c] : 1'b1),
      .tx_space_n(tx_oe[c] ? tx_n[c] : 1'b1), .bus(bus_in[c]), .rd_n(rd_n[c]), .wr(wr[c]),
      .wake_n(wake_n[c]), .drv_data(m_dat[c]), .drv_oe(m_oe[c]));
  end

  usb_parallel_fifo_port #(.NUM_CH(2), .RX_DEPTH(4), .TX_DEPTH(4)) u_dut (
    .clock(clock), .arst_n(arst_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .rd_n(rd_n), .wr(wr), .send_now_wake_n(wake_n), .rx_avail_n(rx_n), .rx_avail_oe(rx_oe),
    .tx_space_n(tx_n), .tx_space_oe(tx_oe), .fifo_mode_en(mode), .remote_wake_en(rwe),
    .suspend_indicator_n(susp), .usb_rx_valid(rxv), .usb_rx_data(rxd), .usb_rx_ready(rxr),
    .usb_tx_valid(txv), .usb_tx_data(txd), .usb_tx_ready(txr), .send_now(snow), .resume_req(resm));

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // usb side push into the receive fifo
  task automatic push_rx(input int c, input byte_t b);
    @(negedge clock);
    rxv[c] = 1'b1;
    rxd[c] = b;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      if (rxr[c] === 1'b1) break;
    end
    @(negedge clock);
    rxv[c] = 1'b0;
  endtask

  // usb side pop from the transmit fifo
  task automatic pop_tx(output byte_t b);
    @(negedge clock);
    txr[0] = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      if (txv[0] === 1'b1) break;
    end
    b = (txv[0] === 1'b1) ? txd[0] : 8'hXX;
    @(negedge clock);
    txr[0] = 1'b0;
  endtask

  // controller read, compared unless blind
  task automatic rd(input int c, input bit blind, input byte_t exp, input string what);
    byte_t b;
    bit    ok;
    if (c == 0) g_ch[0].u_mcu.read_byte(blind, b, ok);
    else g_ch[1].u_mcu.read_byte(blind, b, ok);
    chk({what, " flag"}, 8'h01, {7'h00, ok});
    if (!blind) chk(what, exp, b);
  endtask

  task automatic wrb(input bit blind, input byte_t b);
    bit ok;
    g_ch[0].u_mcu.write_byte(blind, b, ok);
    chk("tx flag seen", 8'h01, {7'h00, ok});
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_rx();
    push_rx(0, 8'hA5);
    push_rx(0, 8'h5A);
    push_rx(0, 8'hC3);
    rd(0, 1'b0, 8'hA5, "rx byte 0");
    rd(0, 1'b0, 8'h5A, "rx byte 1");
    rd(0, 1'b0, 8'hC3, "rx byte 2");
    chk("rx flag empty", 8'h01, {7'h00, rx_n[0]});
    chk("bus released", 8'h00, {7'h00, bus_oe[0]});
    rd(0, 1'b1, 8'h00, "empty read");
    push_rx(0, 8'h3C);
    rd(0, 1'b0, 8'h3C, "rx after empty read");
  endtask

  task automatic t_tx();
    byte_t b;
    for (int i = 1; i <= 4; i++) wrb(1'b0, 8'(8'h11 * i));
    repeat (8) @(negedge clock);
    chk("tx flag full", 8'h01, {7'h00, tx_n[0]});
    wrb(1'b1, 8'h55);
    for (int i = 1; i <= 4; i++) begin
      pop_tx(b);
      chk("tx byte", 8'(8'h11 * i), b);
    end
    repeat (4) @(negedge clock);
    chk("tx drained", 8'h00, {7'h00, txv[0]});
    repeat (8) @(negedge clock);
    chk("tx flag room", 8'h00, {7'h00, tx_n[0]});
  endtask

  task automatic t_wake(input logic s, input logic w, input int exp_s, input int exp_r);
    int ns;
    int nr;
    ns = 0;
    nr = 0;
    @(negedge clock);
    susp[0] = s;
    rwe[0] = w;
    fork
      g_ch[0].u_mcu.wake_pulse();
      repeat (14) begin
        @(posedge clock);
        if (snow[0] === 1'b1) ns++;
        if (resm[0] === 1'b1) nr++;
      end
    join
    chk("send_now pulses", 8'(exp_s), 8'(ns));
    chk("resume pulses", 8'(exp_r), 8'(nr));
  endtask

  // both channels at once
  task automatic t_dual();
    byte_t b;
    push_rx(1, 8'h81);
    fork
      rd(1, 1'b0, 8'h81, "ch1 read byte");
      begin
        wrb(1'b0, 8'h9E);
        pop_tx(b);
        chk("ch0 tx byte", 8'h9E, b);
      end
    join
  endtask

  // channel 1 out of fifo mode: flags released, strobes ignored
  task automatic t_mode_off();
    @(negedge clock);
    mode[1] = 1'b0;
    push_rx(1, 8'h42);
    rd(1, 1'b1, 8'h00, "ch1 mode off read");
    chk("ch1 flags off", 8'h05, {4'h0, rx_oe, tx_oe});
    @(negedge clock);
    mode[1] = 1'b1;
    rd(1, 1'b0, 8'h42, "ch1 byte kept");
  endtask

  // ----------------------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    {mode, rwe, susp, rxv, txr} = 10'h300;
    rxd = '0;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    repeat (20) @(negedge clock);
    chk("flag enables in reset", 8'h00, {4'h0, rx_oe, tx_oe});
    arst_n = 1'b1;
    repeat (8) @(negedge clock);
    chk("flags after reset", 8'h3C, {2'h0, rx_oe, tx_oe, tx_n});
    t_rx();
    t_tx();
    t_wake(1'b0, 1'b0, 1, 0);
    t_wake(1'b1, 1'b1, 0, 1);
    t_wake(1'b1, 1'b0, 0, 0);
    t_wake(1'b0, 1'b1, 1, 0);
    t_dual();
    t_mode_off();
    tally_and_finish();
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
endmodule
